// file: rtl/fpwm_top.sv
// Purpose: Rate and slope registers of three fan drive outputs behind an Avalon-MM slave.
// Assumes: Byte addresses are four times the register index; one wait state per access.
// Notes:   Automatic duty values arrive from the control loop on the same clock.
`timescale 1ns/1ps
`include "fpwm_defs.svh"

// How it works
// - Three consecutive registers pair channels with outputs
// - Each register resets to c4
// - Lock bit makes the three registers read-only
// - Locked writes are dropped, values kept
// - Bits 2:0 pick the low drive rate
// - Bit 3 selects high rate drive
// - High rate ignores pulse stretching
// - Bits 7:4 hold the temperature span
// - Behaviour select picks channel, full, off, manual
module fpwm_top #(
  parameter int CLK_HZ      = `FPWM_CLK_HZ,
  parameter int HF_STEP_CYC = `FPWM_HF_STEP_CYC
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Automatic duty from remote 1, local, remote 2
  input  wire logic [7:0]  auto_duty_r1_i,
  input  wire logic [7:0]  auto_duty_loc_i,
  input  wire logic [7:0]  auto_duty_r2_i,
  // Drive and status
  output logic [2:0]       fan_drive_output_o,
  output logic [11:0]      temperature_span_o,
  output logic [2:0]       high_rate_drive_select_o,
  output logic             cfg_locked_o
);

  fpwm_pkg::fpwm_cfg_t  cfg_q  [3];
  fpwm_pkg::fpwm_mode_t mode_q [3];
  logic [7:0]           duty_q [3];
  logic                 lock_q;
  logic                 ack_q;
  logic [7:0]           idx;
  logic                 req;
  logic                 wr_acc;
  logic                 rd_first;
  logic                 be0;
  logic [2:0]           hit_cfg;
  logic [2:0]           hit_mode;
  logic [2:0]           hit_duty;
  logic                 hit_lock;
  logic [7:0]           rd_sel;
  logic [7:0]           eff_duty [3];
  logic [23:0]          lf_step  [3];

  // Step length of one phase slot for a low rate code
  function automatic logic [23:0] lf_cycles(input logic [2:0] code);
    longint f;
    f = 64'd0;
    unique case (code)
      3'h0: f = `FPWM_F0_CHZ;
      3'h1: f = `FPWM_F1_CHZ;
      3'h2: f = `FPWM_F2_CHZ;
      3'h3: f = `FPWM_F3_CHZ;
      3'h4: f = `FPWM_F4_CHZ;
      3'h5: f = `FPWM_F5_CHZ;
      3'h6: f = `FPWM_F6_CHZ;
      3'h7: f = `FPWM_F7_CHZ;
    endcase
    return 24'((longint'(CLK_HZ) * 100) / (f * `FPWM_STEPS));
  endfunction

  // Larger of two duties
  function automatic logic [7:0] dmax(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction

  // Bus decode, one wait state per access
  assign idx               = avs_address_i[9:2];
  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_acc            = avs_write_i & ack_q;
  assign rd_first          = avs_read_i & ~ack_q;
  assign be0               = avs_byteenable_i[0];
  assign hit_lock          = (idx == `FPWM_IDX_LOCK);
  assign hit_cfg[0]        = (idx == `FPWM_IDX_CFG0);
  assign hit_cfg[1]        = (idx == `FPWM_IDX_CFG1);
  assign hit_cfg[2]        = (idx == `FPWM_IDX_CFG2);

  // Per output decode and duty selection
  for (genvar i = 0; i < 3; i++) begin : g_out
    assign hit_mode[i] = (idx == `FPWM_IDX_MODE0 + 8'(i));
    assign hit_duty[i] = (idx == `FPWM_IDX_DUTY0 + 8'(i));
    assign lf_step[i]  = lf_cycles(cfg_q[i].drive_rate_select);
    assign temperature_span_o[4*i +: 4]  = cfg_q[i].temperature_span;
    assign high_rate_drive_select_o[i]   = cfg_q[i].high_rate_drive_select;

    // Duty source chosen by the behaviour code
    always_comb begin
      unique case (mode_q[i].output_behaviour_select)
        `FPWM_BH_REMOTE1: eff_duty[i] = auto_duty_r1_i;
        `FPWM_BH_LOCAL:   eff_duty[i] = auto_duty_loc_i;
        `FPWM_BH_REMOTE2: eff_duty[i] = auto_duty_r2_i;
        `FPWM_BH_FULL:    eff_duty[i] = `FPWM_FULL_DUTY;
        `FPWM_BH_OFF:     eff_duty[i] = 8'h00;
        `FPWM_BH_MAX_LR2: eff_duty[i] = dmax(auto_duty_loc_i, auto_duty_r2_i);
        `FPWM_BH_MAX_ALL: eff_duty[i] = dmax(auto_duty_r1_i, dmax(auto_duty_loc_i, auto_duty_r2_i));
        `FPWM_BH_MANUAL:  eff_duty[i] = duty_q[i];
      endcase
    end

    // Rate and slope register, frozen once locked
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cfg_q[i] <= fpwm_pkg::fpwm_cfg_t'(`FPWM_CFG_RST);
      end else if (wr_acc && be0 && hit_cfg[i] && !lock_q) begin
        cfg_q[i] <= fpwm_pkg::fpwm_cfg_t'(avs_writedata_i[7:0]);
      end
    end

    // Behaviour and manual duty registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mode_q[i] <= fpwm_pkg::fpwm_mode_t'(`FPWM_MODE_RST);
        duty_q[i] <= `FPWM_DUTY_RST;
      end else if (wr_acc && be0) begin
        if (hit_mode[i]) begin
          mode_q[i] <= fpwm_pkg::fpwm_mode_t'(avs_writedata_i[3:0]);
        end
        if (hit_duty[i]) begin
          duty_q[i] <= avs_writedata_i[7:0];
        end
      end
    end

    fpwm_chan u_chan (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .lf_step_i  (lf_step[i]),
      .hf_step_i  (24'(HF_STEP_CYC)),
      .hf_i       (cfg_q[i].high_rate_drive_select),
      .stretch_i  (mode_q[i].stretch_en),
      .duty_i     (eff_duty[i]),
      .pwm_o      (fan_drive_output_o[i])
    );
  end

  // Read mux, unmapped reads give zero
  assign rd_sel = hit_cfg[0]  ? 8'(cfg_q[0])  :
                  hit_cfg[1]  ? 8'(cfg_q[1])  :
                  hit_cfg[2]  ? 8'(cfg_q[2])  :
                  hit_mode[0] ? {4'h0, mode_q[0]} :
                  hit_mode[1] ? {4'h0, mode_q[1]} :
                  hit_mode[2] ? {4'h0, mode_q[2]} :
                  hit_duty[0] ? duty_q[0] :
                  hit_duty[1] ? duty_q[1] :
                  hit_duty[2] ? duty_q[2] :
                  hit_lock    ? {7'h00, lock_q} : 8'h00;

  // Handshake, read data and sticky lock
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_q          <= 1'b0;
      lock_q         <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_q <= req & ~ack_q;
      if (rd_first) begin
        avs_readdata_o <= {24'h000000, rd_sel};
      end
      if (wr_acc && be0 && hit_lock && avs_writedata_i[`FPWM_LOCK_BIT]) begin
        lock_q <= 1'b1;
      end
    end
  end

  assign cfg_locked_o = lock_q;

  // Checks on registers, lock, handshake and drive outputs
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_wr_cfg0;
    avs_write_i && !avs_waitrequest_o && hit_cfg[0] && be0;
  endsequence

  sequence s_rd_cfg0;
    avs_read_i && avs_waitrequest_o && hit_cfg[0] ##1 avs_read_i && !avs_waitrequest_o;
  endsequence

  a_cfg_reset_val: assert property ($rose(rst_n_i) |->
    cfg_q[0] == `FPWM_CFG_RST && cfg_q[1] == `FPWM_CFG_RST && cfg_q[2] == `FPWM_CFG_RST)
    else $error("config register not at reset value");
  a_write_lands: assert property (s_wr_cfg0 ##0 !lock_q |=> 8'(cfg_q[0]) == $past(avs_writedata_i[7:0]))
    else $error("unlocked write did not land");
  a_locked_drop: assert property (s_wr_cfg0 ##0 lock_q |=> $stable(cfg_q[0]))
    else $error("locked write changed register");
  a_lock_sticky: assert property (lock_q |=> lock_q)
    else $error("lock bit cleared");
  a_read_back: assert property (s_rd_cfg0 |-> avs_readdata_o[7:0] == 8'(cfg_q[0]))
    else $error("read data mismatch");
  a_wait_bound: assert property (req |-> ##[0:1] !avs_waitrequest_o)
    else $error("waitrequest held too long");
  a_rate_kept: assert property (cfg_q[0].high_rate_drive_select
    && !(avs_write_i && !avs_waitrequest_o && hit_cfg[0] && be0) |=> $stable(cfg_q[0].drive_rate_select))
    else $error("rate code changed in high rate mode");
  a_off_low: assert property ((mode_q[0].output_behaviour_select == `FPWM_BH_OFF)[*3]
    |-> !fan_drive_output_o[0])
    else $error("disabled output driven");
  a_full_high: assert property ((mode_q[0].output_behaviour_select == `FPWM_BH_FULL)[*3]
    |-> fan_drive_output_o[0])
    else $error("full speed output low");
  a_lock_set: assert property (wr_acc && be0 && hit_lock && avs_writedata_i[`FPWM_LOCK_BIT] |=> lock_q)
    else $error("lock write did not set lock");
  a_wait_first: assert property (req && !ack_q |-> avs_waitrequest_o)
    else $error("request taken without a wait state");

endmodule

// file: rtl/fpwm_defs.svh
// Purpose: Offsets, field positions, reset values and timing figures of the fan drive configuration block.
// Assumes: 50 MHz core clock, register index times four is the byte address.
// Notes:   Frequencies are held in hundredths of a hertz.
`ifndef FPWM_DEFS_SVH
`define FPWM_DEFS_SVH

// Register indices
`define FPWM_IDX_CFG0      8'h5f
`define FPWM_IDX_CFG1      8'h60
`define FPWM_IDX_CFG2      8'h61
`define FPWM_IDX_LOCK      8'h40
`define FPWM_IDX_MODE0     8'h70
`define FPWM_IDX_DUTY0     8'h74

// Reset values
`define FPWM_CFG_RST       8'hc4
`define FPWM_MODE_RST      4'h4
`define FPWM_DUTY_RST      8'h00

// Field positions
`define FPWM_LOCK_BIT      0
`define FPWM_STRETCH_BIT   3

// Behaviour select codes
`define FPWM_BH_REMOTE1    3'h0
`define FPWM_BH_LOCAL      3'h1
`define FPWM_BH_REMOTE2    3'h2
`define FPWM_BH_FULL       3'h3
`define FPWM_BH_OFF        3'h4
`define FPWM_BH_MAX_LR2    3'h5
`define FPWM_BH_MAX_ALL    3'h6
`define FPWM_BH_MANUAL     3'h7

// Low rate table in centihertz
`define FPWM_F0_CHZ        1100
`define FPWM_F1_CHZ        1470
`define FPWM_F2_CHZ        2210
`define FPWM_F3_CHZ        2940
`define FPWM_F4_CHZ        3530
`define FPWM_F5_CHZ        4410
`define FPWM_F6_CHZ        5880
`define FPWM_F7_CHZ        8820

// Timing
`define FPWM_CLK_HZ        50000000
`define FPWM_STEPS         256
`define FPWM_HF_STEP_CYC   8
`define FPWM_STRETCH_STEPS 8'h20
`define FPWM_FULL_DUTY     8'hff

`endif

// file: rtl/fpwm_pkg.sv
// Purpose: Types shared by the fan drive configuration block.
// Assumes: Constants live in fpwm_defs.svh.
// Notes:   The config struct matches the register bit layout.
package fpwm_pkg;

  // One rate and slope register: span [7:4], high rate [3], rate [2:0]
  typedef struct packed {
    logic [3:0] temperature_span;
    logic       high_rate_drive_select;
    logic [2:0] drive_rate_select;
  } fpwm_cfg_t;

  // Per output behaviour register
  typedef struct packed {
    logic       stretch_en;
    logic [2:0] output_behaviour_select;
  } fpwm_mode_t;

endpackage

// file: rtl/fpwm_chan.sv
// Purpose: One fan drive output: step divider, 256 step phase counter and compare.
// Assumes: Step lengths come from the register logic on the same clock.
// Notes:   Pulse stretching only applies in low rate mode.
`timescale 1ns/1ps
`include "fpwm_defs.svh"

module fpwm_chan (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Settings
  input  wire logic [23:0] lf_step_i,
  input  wire logic [23:0] hf_step_i,
  input  wire logic        hf_i,
  input  wire logic        stretch_i,
  input  wire logic [7:0]  duty_i,
  // Drive
  output logic             pwm_o
);

  logic [23:0] div_q;
  logic [7:0]  phase_q;
  logic        step_en;
  logic [23:0] reload;
  logic        stretch_on;
  logic        pwm_d;

  // Step enable and divider reload, high rate takes its own length
  assign step_en    = (div_q == 24'h000000);
  assign reload     = hf_i ? hf_step_i - 24'h000001 : lf_step_i - 24'h000001;
  // Stretching is ignored in high rate mode
  assign stretch_on = stretch_i & ~hf_i & (duty_i != 8'h00)
                      & (phase_q < `FPWM_STRETCH_STEPS);
  assign pwm_d      = (duty_i == `FPWM_FULL_DUTY) | (phase_q < duty_i) | stretch_on;

  // Divider and phase counter
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q   <= 24'h000000;
      phase_q <= 8'h00;
      pwm_o   <= 1'b0;
    end else begin
      div_q <= step_en ? reload : div_q - 24'h000001;
      if (step_en) begin
        phase_q <= phase_q + 8'h01;
      end
      pwm_o <= pwm_d;
    end
  end

  // In high rate mode only the duty compare decides the level
  a_hf_no_stretch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (hf_i && phase_q >= duty_i && duty_i != `FPWM_FULL_DUTY) |=> !pwm_o)
    else $error("stretch acted in high rate mode");

endmodule

// file: tb/fpwm_fan_model.sv
// Purpose: Fan on one drive output: measures high time and period of the drive level.
// Assumes: Same clock as the drive logic; drive is a plain level.
// Notes:   Reports the last complete high pulse and rise to rise period in clock cycles.
`timescale 1ns/1ps

module fpwm_fan_model (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Drive from the block
  input  wire logic        drive_i,
  // Measurements
  output logic [15:0]      high_len_o,
  output logic [15:0]      period_o
);
  logic        drive_q;
  logic [15:0] hi_cnt_q;
  logic [15:0] per_cnt_q;

  // Count high cycles and cycles between rising edges
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_q    <= 1'b0;
      hi_cnt_q   <= 16'h0000;
      per_cnt_q  <= 16'h0000;
      high_len_o <= 16'h0000;
      period_o   <= 16'h0000;
    end else begin
      drive_q <= drive_i;
      if (drive_i && !drive_q) begin
        period_o  <= per_cnt_q;  // Last full period
        per_cnt_q <= 16'h0001;
        hi_cnt_q  <= 16'h0001;
      end else begin
        per_cnt_q <= per_cnt_q + 16'h0001;
        if (drive_i) hi_cnt_q <= hi_cnt_q + 16'h0001;
        if (!drive_i && drive_q) high_len_o <= hi_cnt_q;
      end
    end
  end
endmodule

// file: tb/test_fan_pwm_rate_and_slope_config.sv
// Purpose: Self-checking bench for the fan drive rate and slope registers.
// Assumes: Master waits for waitrequest low; high rate step shortened to 2 cycles.
// Notes:   Register byte address is four times the register index.
`timescale 1ns/1ps
`include "fpwm_defs.svh"

module test_fan_pwm_rate_and_slope_config;
  localparam int HF  = 2;
  localparam int CLK = 25600;
  // Low rate step of code 111 in clock cycles
  localparam int LF7 = (CLK * 100) / (`FPWM_F7_CHZ * `FPWM_STEPS);
  logic [7:0]  ad_r1 = 8'h00;
  logic [7:0]  ad_loc = 8'h00;
  logic [7:0]  ad_r2 = 8'h00;
  logic        core_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [9:0]  addr = 10'h000;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic [2:0]  drive;
  logic [11:0] span;
  logic [2:0]  hf_sel;
  logic        locked;
  logic [15:0] high_len;
  logic [15:0] period;
  logic [31:0] q;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  fpwm_top #(.CLK_HZ(CLK), .HF_STEP_CYC(HF)) u_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(4'h1), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_req), .auto_duty_r1_i(ad_r1), .auto_duty_loc_i(ad_loc),
    .auto_duty_r2_i(ad_r2), .fan_drive_output_o(drive), .temperature_span_o(span),
    .high_rate_drive_select_o(hf_sel), .cfg_locked_o(locked));

  fpwm_fan_model u_fan (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .drive_i(drive[0]), .high_len_o(high_len),
    .period_o(period));

  // Clock at 50 MHz
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt = error_cnt + 1;
      results();
    end
  end

  // Print the verdict and stop
  task automatic results();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One bus access, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk_i);
    addr  <= {idx, 2'b00};
    rd_en <= !wr;
    wr_en <= wr;
    wdata <= {24'h000000, d};
    do begin
      @(posedge core_clk_i);
    end while (wait_req !== 1'b0);
    q = rdata;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  // Read one register and compare
  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(name, {24'h000000, exp}, q);
  endtask

  initial begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    // Power-on values and outputs
    rd_chk("cfg0 reset", `FPWM_IDX_CFG0, 8'hc4);
    rd_chk("cfg1 reset", `FPWM_IDX_CFG1, 8'hc4);
    rd_chk("cfg2 reset", `FPWM_IDX_CFG2, 8'hc4);
    chk("span reset", {20'h0, 12'hccc}, {20'h0, span});
    chk("hf reset", {29'h0, 3'b000}, {29'h0, hf_sel});
    rd_chk("unmapped", 8'h63, 8'h00);
    // Distinct values per register, back to back
    bus(1'b1, `FPWM_IDX_CFG0, 8'h5b);
    bus(1'b1, `FPWM_IDX_CFG1, 8'hf7);
    bus(1'b1, `FPWM_IDX_CFG2, 8'h00);
    rd_chk("cfg0 rw", `FPWM_IDX_CFG0, 8'h5b);
    rd_chk("cfg1 rw", `FPWM_IDX_CFG1, 8'hf7);
    rd_chk("cfg2 rw", `FPWM_IDX_CFG2, 8'h00);
    chk("span fields", {20'h0, 12'h0f5}, {20'h0, span});
    chk("hf fields", {29'h0, 3'b001}, {29'h0, hf_sel});
    // High rate drive on output 1: manual duty with stretch enabled
    bus(1'b1, `FPWM_IDX_CFG0, 8'hc8);
    bus(1'b1, `FPWM_IDX_DUTY0, 8'h10);
    bus(1'b1, `FPWM_IDX_MODE0, 8'h0f);
    repeat (3 * 256 * HF) @(posedge core_clk_i);
    chk("hf period", 32'(256 * HF), {16'h0, period});
    chk("hf high", 32'(16 * HF), {16'h0, high_len});
    chk("out2 off", 32'h0, {31'h0, drive[1]});
    // Low rate drive on output 1: stretch now acts
    bus(1'b1, `FPWM_IDX_CFG0, 8'hc7);
    repeat (4 * 256 * LF7) @(posedge core_clk_i);
    chk("lf period", 32'(256 * LF7), {16'h0, period});
    chk("lf stretch", 32'(`FPWM_STRETCH_STEPS * LF7), {16'h0, high_len});
    // Automatic duty sources on output 1, stretch off
    ad_r1  <= 8'h20;
    ad_loc <= 8'h30;
    ad_r2  <= 8'h08;
    bus(1'b1, `FPWM_IDX_MODE0, 8'h02);
    repeat (4 * 256 * LF7) @(posedge core_clk_i);
    chk("remote2 duty", 32'(8 * LF7), {16'h0, high_len});
    bus(1'b1, `FPWM_IDX_MODE0, 8'h06);
    repeat (4 * 256 * LF7) @(posedge core_clk_i);
    chk("max duty", 32'(48 * LF7), {16'h0, high_len});
    // Full speed holds the output high
    bus(1'b1, `FPWM_IDX_MODE0, 8'h03);
    repeat (2 * 256 * HF) @(posedge core_clk_i);
    chk("full speed", 32'h1, {31'h0, drive[0]});
    // Lock, then a write must be dropped
    bus(1'b1, `FPWM_IDX_LOCK, 8'h01);
    @(posedge core_clk_i);
    chk("locked", 32'h1, {31'h0, locked});
    bus(1'b1, `FPWM_IDX_CFG0, 8'h17);
    bus(1'b1, `FPWM_IDX_CFG2, 8'hff);
    rd_chk("cfg0 locked", `FPWM_IDX_CFG0, 8'hc7);
    rd_chk("cfg2 locked", `FPWM_IDX_CFG2, 8'h00);
    chk("span locked", {20'h0, 12'h0fc}, {20'h0, span});
    results();
  end
endmodule
